// ---- gpe_pkg.sv ----
package gpe_pkg;
    // register byte offsets on the plain bus
    localparam logic [2:0] GPE_OFF_PIN_LEVELS = 3'h0;
    localparam logic [2:0] GPE_OFF_DIRECTION = 3'h1;
    localparam logic [2:0] GPE_OFF_OUTPUT_LATCH = 3'h2;
    localparam logic [2:0] GPE_OFF_ANALOG_SELECT = 3'h3;
    localparam logic [2:0] GPE_OFF_PULLUP_ENABLE = 3'h4;

    // widths
    localparam int GPE_IO_PINS = 3;
    localparam int GPE_ALL_PINS = 4;
    localparam int GPE_SYNC_BITS = 7;

    // field positions
    localparam int GPE_INPUT_ONLY_BIT = 3;
    localparam int GPE_PIN3_PULLUP_BIT = 3;

    // values after reset
    localparam logic [2:0] GPE_RST_DIRECTION = 3'h7;
    localparam logic [2:0] GPE_RST_ANALOG = 3'h7;
    localparam logic [2:0] GPE_RST_LATCH = 3'h0;
    localparam logic GPE_RST_PULLUP = 1'b1;
    localparam logic [7:0] GPE_RST_RDATA = 8'h00;

    // synchroniser depth in cycles
    localparam int GPE_SYNC_STAGES = 2;
endpackage

// ---- gpe_sync.sv ----
`timescale 1ns/1ns
module gpe_sync
    import gpe_pkg::*;
#(
    parameter int WIDTH = GPE_SYNC_BITS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // asynchronous levels in, clean levels out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // two flops per bit; the first is read by the second only
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    meta_ff[gi] <= 1'b0;
                    sync_ff[gi] <= 1'b0;
                end else begin
                    meta_ff[gi] <= async_i[gi];
                    sync_ff[gi] <= meta_ff[gi];
                end
            end
        end
    endgenerate

    assign sync_o = sync_ff;
endmodule

// ---- gpe_port.sv ----
`timescale 1ns/1ns
// Contract
// - pin register reads present pin levels
// - direction 1 is input, 0 drives; reset 1
// - direction bit 3 reads 1, 7..4 read 0
// - pin register write goes to output latch
// - pin read gives pins; latch reads latch
// - analog select 1 kills digital input; reset 1
// - pull-up bit 3 enables pin 3 pull-up
// - global disable forces all pull-ups off
// - pull-up off while pin is output
// - reduced variant reads pin bits 0
// - port writes act as read-modify-write
// - pin 3 reads 0 when master clear on
// - analog pin reads 0 digitally
// - highest priority output function owns pin
module gpe_port
    import gpe_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // register bus
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // device configuration levels
    input wire logic global_pullup_disable_i,
    input wire logic master_clear_enable_i,
    input wire logic reduced_variant_i,
    // pins
    input wire logic [3:0] pin_level_bits_i,
    output logic [2:0] pin_out_o,
    output logic [2:0] pin_oe_o,
    output logic [2:0] digital_in_en_o,
    output logic pin3_pullup_o,
    // higher priority peripherals, same clock
    input wire logic [2:0] lcd_oe_i,
    input wire logic [2:0] lcd_out_i,
    input wire logic [2:0] ccp_oe_i,
    input wire logic [2:0] ccp_out_i
);

    // bus address decode, used for reads and writes
    function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
        hit = (a == off);
    endfunction

    logic [2:0] direction_bits_ff;
    logic [2:0] output_latch_ff;
    logic [2:0] analog_select_bits_ff;
    logic pin3_pullup_bit_ff;
    logic [7:0] rdata_ff;
    logic [2:0] pin_out_ff;
    logic [2:0] pin_oe_ff;
    logic [2:0] din_en_ff;
    logic pullup_ff;

    logic [6:0] sync_lv;
    logic [3:0] pin_sync;
    logic gpud_sync;
    logic master_clear_enable_sync;
    logic reduced_sync;
    logic [7:0] pin_read;
    logic [7:0] dir_read;
    logic [7:0] lat_read;
    logic [7:0] ans_read;
    logic [7:0] pu_read;
    logic [7:0] nxt_rdata;
    logic [2:0] nxt_pin_out;
    logic [2:0] nxt_pin_oe;
    logic nxt_pullup;

    // every outside level passes two flops first
    gpe_sync #(
        .WIDTH(GPE_SYNC_BITS)
    ) u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .async_i({reduced_variant_i, master_clear_enable_i,
                  global_pullup_disable_i, pin_level_bits_i}),
        .sync_o(sync_lv)
    );

    assign pin_sync = sync_lv[3:0];
    assign gpud_sync = sync_lv[4];
    assign master_clear_enable_sync = sync_lv[5];
    assign reduced_sync = sync_lv[6];

    // direction register; bit 3 has no storage
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            direction_bits_ff <= GPE_RST_DIRECTION;
        end else if (wr_i && hit(addr_i, GPE_OFF_DIRECTION)) begin
            direction_bits_ff <= wdata_i[2:0];
        end
    end

    // output latch, written through either address
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            output_latch_ff <= GPE_RST_LATCH;
        end else if (wr_i && hit(addr_i, GPE_OFF_PIN_LEVELS)) begin
            // the cpu's read-modify-write result arrives as the full byte
            output_latch_ff <= wdata_i[2:0];
        end else if (wr_i && hit(addr_i, GPE_OFF_OUTPUT_LATCH)) begin
            output_latch_ff <= wdata_i[2:0];
        end
    end

    // analog select register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            analog_select_bits_ff <= GPE_RST_ANALOG;
        end else if (wr_i && hit(addr_i, GPE_OFF_ANALOG_SELECT)) begin
            analog_select_bits_ff <= wdata_i[2:0];
        end
    end

    // pull-up enable, same value on every reset
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin3_pullup_bit_ff <= GPE_RST_PULLUP;
        end else if (wr_i && hit(addr_i, GPE_OFF_PULLUP_ENABLE)) begin
            pin3_pullup_bit_ff <= wdata_i[GPE_PIN3_PULLUP_BIT];
        end
    end

    // readback images; reduced variant hides pins 2..0
    always_comb begin
        pin_read = 8'h00;
        pin_read[2:0] = pin_sync[2:0] & ~analog_select_bits_ff;
        if (reduced_sync) begin
            pin_read[2:0] = 3'h0;
        end
        pin_read[GPE_INPUT_ONLY_BIT] = pin_sync[3] & ~master_clear_enable_sync;
        dir_read = 8'h00;
        dir_read[GPE_INPUT_ONLY_BIT] = 1'b1;
        dir_read[2:0] = reduced_sync ? 3'h0 : direction_bits_ff;
        lat_read = 8'h00;
        lat_read[2:0] = reduced_sync ? 3'h0 : output_latch_ff;
        ans_read = 8'h00;
        ans_read[2:0] = reduced_sync ? 3'h0 : analog_select_bits_ff;
        pu_read = 8'h00;
        pu_read[GPE_PIN3_PULLUP_BIT] = pin3_pullup_bit_ff;
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (hit(addr_i, GPE_OFF_PIN_LEVELS)) begin
            nxt_rdata = pin_read;
        end else if (hit(addr_i, GPE_OFF_DIRECTION)) begin
            nxt_rdata = dir_read;
        end else if (hit(addr_i, GPE_OFF_OUTPUT_LATCH)) begin
            nxt_rdata = lat_read;
        end else if (hit(addr_i, GPE_OFF_ANALOG_SELECT)) begin
            nxt_rdata = ans_read;
        end else if (hit(addr_i, GPE_OFF_PULLUP_ENABLE)) begin
            nxt_rdata = pu_read;
        end
    end

    // read data stands in the cycle after each read strobe, zero otherwise
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_ff <= GPE_RST_RDATA;
        end else begin
            rdata_ff <= rd_i ? nxt_rdata : GPE_RST_RDATA;
        end
    end

    // output priority: lcd, then ccp, then the port latch
    always_comb begin
        nxt_pin_oe = 3'h0;
        nxt_pin_out = 3'h0;
        for (int i = 0; i < GPE_IO_PINS; i++) begin
            if (lcd_oe_i[i]) begin
                nxt_pin_oe[i] = 1'b1;
                nxt_pin_out[i] = lcd_out_i[i];
            end else if (ccp_oe_i[i]) begin
                nxt_pin_oe[i] = 1'b1;
                nxt_pin_out[i] = ccp_out_i[i];
            end else begin
                // analog select does not stop the driver; software must set input
                nxt_pin_oe[i] = ~direction_bits_ff[i];
                nxt_pin_out[i] = output_latch_ff[i];
            end
            if (reduced_sync) begin
                nxt_pin_oe[i] = 1'b0;
            end
        end
    end

    // pin 3 is never an output, so its direction stays input
    assign nxt_pullup = pin3_pullup_bit_ff & ~gpud_sync & dir_read[GPE_INPUT_ONLY_BIT];

    // registered pin controls; one cycle behind the registers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_out_ff <= GPE_RST_LATCH;
            pin_oe_ff <= 3'h0;
            din_en_ff <= 3'h0;
            pullup_ff <= 1'b0;
        end else begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= nxt_pin_oe;
            din_en_ff <= ~analog_select_bits_ff;
            pullup_ff <= nxt_pullup;
        end
    end

    assign rdata_o = rdata_ff;
    assign pin_out_o = pin_out_ff;
    assign pin_oe_o = pin_oe_ff;
    assign digital_in_en_o = din_en_ff;
    assign pin3_pullup_o = pullup_ff;

    // checks on the block's own outputs
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    AST_DIR_READ_SHAPE: assert property (
        rd_i && addr_i == GPE_OFF_DIRECTION |=> rdata_o[7:3] == 5'h01)
        else $error("direction readback upper bits wrong");

    AST_LATCH_WRITE: assert property (
        wr_i && addr_i == GPE_OFF_PIN_LEVELS && !reduced_sync
        ##1 rd_i && addr_i == GPE_OFF_OUTPUT_LATCH && !reduced_sync
        |=> rdata_o[2:0] == $past(wdata_i[2:0], 2'd2) && rdata_o[7:3] == 5'h00)
        else $error("pin write did not reach latch");

    AST_PIN_READ: assert property (
        rd_i && addr_i == GPE_OFF_PIN_LEVELS && !reduced_sync
        |=> rdata_o[2:0] == ($past(pin_sync[2:0]) & ~$past(analog_select_bits_ff)))
        else $error("pin level readback wrong");

    AST_ANALOG_ZERO: assert property (
        rd_i && addr_i == GPE_OFF_PIN_LEVELS && analog_select_bits_ff[0]
        |=> rdata_o[0] == 1'b0)
        else $error("analog pin read nonzero");

    AST_MCLR_ZERO: assert property (
        rd_i && addr_i == GPE_OFF_PIN_LEVELS && master_clear_enable_sync |=> rdata_o[3] == 1'b0)
        else $error("input-only pin read nonzero under master clear");

    AST_REDUCED_ZERO: assert property (
        rd_i && reduced_sync && addr_i != GPE_OFF_PULLUP_ENABLE |=> rdata_o[2:0] == 3'h0)
        else $error("reduced variant shows pin bits");

    AST_PULLUP_GLOBAL: assert property (
        gpud_sync |=> !pin3_pullup_o)
        else $error("pull-up on despite global disable");

    AST_PULLUP_ON: assert property (
        pin3_pullup_bit_ff && !gpud_sync |=> pin3_pullup_o)
        else $error("pull-up not enabled");

    AST_DRIVE_LATCH: assert property (
        !lcd_oe_i[1] && !ccp_oe_i[1] && !direction_bits_ff[1] && !reduced_sync
        |=> pin_oe_o[1] && pin_out_o[1] == $past(output_latch_ff[1]))
        else $error("latch not driven on output pin");

    AST_HIZ_INPUT: assert property (
        !lcd_oe_i[2] && !ccp_oe_i[2] && direction_bits_ff[2] |=> !pin_oe_o[2])
        else $error("input pin driven");

    AST_PRIORITY: assert property (
        lcd_oe_i[1] && ccp_oe_i[1] && !reduced_sync |=> pin_oe_o[1] && pin_out_o[1] == $past(lcd_out_i[1]))
        else $error("lower priority function won the pin");

    AST_DIN_BUFFER: assert property (
        wr_i && addr_i == GPE_OFF_ANALOG_SELECT ##1 1'b1 |=> digital_in_en_o == ~$past(wdata_i[2:0], 2'd2))
        else $error("digital input buffer enable wrong");

    AST_RDATA_IDLE: assert property (
        !rd_i |=> rdata_o == 8'h00)
        else $error("read data outside answer cycle");

    COV_PORT_WRITE_READ: cover property (
        wr_i && addr_i == GPE_OFF_PIN_LEVELS ##1 rd_i && addr_i == GPE_OFF_PIN_LEVELS);
    COV_PERIPH_OWNS: cover property (ccp_oe_i[1] && !direction_bits_ff[1]);
    COV_PULLUP_ACTIVE: cover property (pin3_pullup_o);
    COV_ANALOG_OUTPUT: cover property (analog_select_bits_ff[0] && !direction_bits_ff[0]);

endmodule

// ---- gpe_pins.sv ----
`timescale 1ns/1ns
module gpe_pins (
    // clock
    input wire logic clk_i,
    // port side of the pins
    input wire logic [2:0] pin_out_i,
    input wire logic [2:0] pin_oe_i,
    input wire logic pin3_pullup_i,
    // board side drivers
    input wire logic [3:0] ext_en_i,
    input wire logic [3:0] ext_val_i,
    output logic [3:0] level_o
);
    logic [3:0] last_ff;
    // a floating pin holds nothing, so it shows the inverse of its last level
    always_ff @(posedge clk_i) begin
        last_ff <= level_o;
    end
    // chip driver beats board on pins 2..0; pin 3 only sees board or pull-up
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            level_o[i] = pin_oe_i[i] ? pin_out_i[i] : (ext_en_i[i] ? ext_val_i[i] : ~last_ff[i]);
        end
        level_o[3] = ext_en_i[3] ? ext_val_i[3] : (pin3_pullup_i ? 1'b1 : ~last_ff[3]);
    end
endmodule

// ---- four_pin_gpio_port_e_bench.sv ----
`timescale 1ns/1ns
module four_pin_gpio_port_e_bench import gpe_pkg::*;;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic gpd = 1'b0;
    logic mce = 1'b0;
    logic rv = 1'b0;
    logic [3:0] pins;
    logic [2:0] pin_out;
    logic [2:0] pin_oe;
    logic [2:0] din_en;
    logic pu3;
    logic [2:0] lcd_oe = 3'h0;
    logic [2:0] lcd_out = 3'h0;
    logic [2:0] ccp_oe = 3'h0;
    logic [2:0] ccp_out = 3'h0;
    logic [3:0] ext_en = 4'hF;
    logic [3:0] ext_val = 4'h8;
    int err_count = 0;
    int checks_done = 0;

    // free running system clock
    initial begin
        forever #4 clk_i = ~clk_i;
    end

    gpe_port u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .global_pullup_disable_i(gpd), .master_clear_enable_i(mce),
        .reduced_variant_i(rv), .pin_level_bits_i(pins), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
        .digital_in_en_o(din_en), .pin3_pullup_o(pu3), .lcd_oe_i(lcd_oe), .lcd_out_i(lcd_out),
        .ccp_oe_i(ccp_oe), .ccp_out_i(ccp_out));

    gpe_pins u_pins (.clk_i(clk_i), .pin_out_i(pin_out), .pin_oe_i(pin_oe), .pin3_pullup_i(pu3),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pins));

    task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input string name, input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        cmp(name, exp, rdata_o);
    endtask

    // write then read with no idle cycle between the strobes
    task automatic wr_rd(input logic [2:0] wa, input logic [7:0] d, input logic [2:0] ra,
                         input string name, input logic [7:0] exp);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= wa;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        addr_i <= ra;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        cmp(name, exp, rdata_o);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic stop_test;
        if (err_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // main sequence; fixed waits follow the stated latencies (1 edge, 3 for synced levels)
    initial begin
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        tick(2);
        cmp("pin_oe", {5'h00, pin_oe}, 8'h00);
        cmp("din_en", {5'h00, din_en}, 8'h00);
        cmp("pu3", {7'h00, pu3}, 8'h01);
        rd("dir", GPE_OFF_DIRECTION, 8'h0F);
        rd("latch", GPE_OFF_OUTPUT_LATCH, 8'h00);
        rd("analog", GPE_OFF_ANALOG_SELECT, 8'h07);
        rd("pullup", GPE_OFF_PULLUP_ENABLE, 8'h08);
        rd("unmapped", 3'h5, 8'h00);
        rd("pins", GPE_OFF_PIN_LEVELS, 8'h08);
        // board drives pin 1 high; digital buffers switched on
        @(posedge clk_i);
        ext_val <= 4'hA;
        wr(GPE_OFF_ANALOG_SELECT, 8'h00);
        tick(2);
        cmp("din_en", {5'h00, din_en}, 8'h07);
        rd("pins", GPE_OFF_PIN_LEVELS, 8'h0A);
        wr(GPE_OFF_DIRECTION, 8'hFF);
        rd("dir", GPE_OFF_DIRECTION, 8'h0F);
        wr_rd(GPE_OFF_PIN_LEVELS, 8'hF5, GPE_OFF_OUTPUT_LATCH, "latch", 8'h05);
        rd("pins", GPE_OFF_PIN_LEVELS, 8'h0A);
        wr(GPE_OFF_DIRECTION, 8'h00);
        tick(2);
        cmp("pin_oe", {5'h00, pin_oe}, 8'h07);
        cmp("pin_out", {5'h00, pin_out}, 8'h05);
        cmp("pu3", {7'h00, pu3}, 8'h01);
        tick(2);
        rd("pins", GPE_OFF_PIN_LEVELS, 8'h0D);
        wr(GPE_OFF_OUTPUT_LATCH, 8'h03);
        // lcd and ccp both claim pin 1 and lcd wins, ccp owns pin 0, latch is left with pin 2
        ccp_oe <= 3'h3;
        ccp_out <= 3'h3;
        lcd_oe <= 3'h2;
        lcd_out <= 3'h0;
        tick(2);
        cmp("pin_out", {5'h00, pin_out}, 8'h01);
        wr(GPE_OFF_DIRECTION, 8'h07);
        tick(2);
        cmp("pin_oe", {5'h00, pin_oe}, 8'h03);
        @(posedge clk_i);
        ccp_oe <= 3'h0;
        lcd_oe <= 3'h0;
        wr(GPE_OFF_DIRECTION, 8'h00);
        wr(GPE_OFF_ANALOG_SELECT, 8'h01);
        tick(2);
        cmp("pin_oe", {5'h00, pin_oe}, 8'h07);
        cmp("din_en", {5'h00, din_en}, 8'h06);
        tick(2);
        rd("pins", GPE_OFF_PIN_LEVELS, 8'h0A);
        // software makes the analog pin an input so the driver lets go
        wr(GPE_OFF_DIRECTION, 8'h01);
        tick(2);
        cmp("pin_oe", {5'h00, pin_oe}, 8'h06);
        wr(GPE_OFF_PULLUP_ENABLE, 8'h00);
        tick(2);
        cmp("pu3", {7'h00, pu3}, 8'h00);
        rd("pullup", GPE_OFF_PULLUP_ENABLE, 8'h00);
        wr(GPE_OFF_PULLUP_ENABLE, 8'hFF);
        rd("pullup", GPE_OFF_PULLUP_ENABLE, 8'h08);
        // board lets pin 3 float; only the pull-up can hold it high
        @(posedge clk_i);
        ext_en <= 4'h7;
        ext_val <= 4'h2;
        tick(4);
        rd("pins", GPE_OFF_PIN_LEVELS, 8'h0A);
        @(posedge clk_i);
        gpd <= 1'b1;
        tick(4);
        cmp("pu3", {7'h00, pu3}, 8'h00);
        @(posedge clk_i);
        gpd <= 1'b0;
        mce <= 1'b1;
        tick(4);
        cmp("pu3", {7'h00, pu3}, 8'h01);
        rd("pins", GPE_OFF_PIN_LEVELS, 8'h02);
        // reduced part: pins 2..0 vanish from every register
        @(posedge clk_i);
        mce <= 1'b0;
        rv <= 1'b1;
        tick(4);
        cmp("pin_oe", {5'h00, pin_oe}, 8'h00);
        rd("pins", GPE_OFF_PIN_LEVELS, 8'h08);
        rd("dir", GPE_OFF_DIRECTION, 8'h08);
        rd("latch", GPE_OFF_OUTPUT_LATCH, 8'h00);
        rd("analog", GPE_OFF_ANALOG_SELECT, 8'h00);
        stop_test();
    end
endmodule
